// file: verilog/sbcc_converter.sv
// Converter end: blank/convert control, SAR sequencer and output gating.
// Assumes link inputs come from another device and are synchronised here.
// The comparator is a stand-in: i_analog_code is the code that the input
// would balance, so each bit trial is a plain magnitude compare.
//
// Behaviour
// - Blank high: outputs open, done high
// - Falling blank starts conversion, outputs unchanged
// - Done low, data enabled within 500 ns
// - About 1.5 us after blank high, release
// - Host holds blank high 2 us minimum
// - Blank high mid-conversion aborts, outputs unchanged
// - Blank pulse 2 us restarts conversion
// - Offset pin grounded gives straight binary
// - Offset pin open gives offset binary
// - Unipolar step 9.766 mV, top 9.990 V
// - Pulse mode: host pulses high briefly
// - Multiplex: host selects, waits, reads, blanks
// - Host blanks first within 15 us
// - Bits tested MSB to LSB
`timescale 1ns/1ps
module sbcc_converter (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  sbcc_link_if.device link,
  input wire logic [sbcc_pkg::DATA_W-1:0] i_analog_code,
  output logic o_busy
);
  import sbcc_pkg::*;

  // Synchroniser stages for the link inputs and the comparator code.
  logic bc_s1;
  logic bc_s2;
  logic bc_q;
  logic bip_s1;
  logic bip_s2;
  logic [DATA_W-1:0] ana_s1;
  logic [DATA_W-1:0] ana_s2;
  // Sequencer state, counters and the successive-approximation register.
  sbcc_state_e state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] hi_cnt;
  logic [4:0] div;
  logic trial_en;
  logic [3:0] bit_idx;
  logic [DATA_W-1:0] sar;
  logic [DATA_W-1:0] result;
  logic done_q;
  logic data_en;
  // Level being weighed and the trial word tested against it.
  logic [DATA_W-1:0] level;
  logic [DATA_W-1:0] trial;

  // Two-flop synchronisers; logic reads the second flop, plus bc_q for the blank edge.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bc_s1 <= 1'b1;
      bc_s2 <= 1'b1;
      bc_q <= 1'b1;
      bip_s1 <= 1'b0;
      bip_s2 <= 1'b0;
      ana_s1 <= '0;
      ana_s2 <= '0;
    end else begin
      bc_s1 <= link.blank_conv;
      bc_s2 <= bc_s1;
      bc_q <= bc_s2;
      bip_s1 <= link.bipolar_open;
      bip_s2 <= bip_s1;
      ana_s1 <= i_analog_code;
      ana_s2 <= ana_s1;
    end
  end

  // Bipolar mode shifts the input so zero maps to the MSB-only code.
  always_comb begin
    // Each code step stands for LSB_UV of input, so the top code is reached
    // near TOP_MV; nothing analog is modelled beyond that weighting.
    level = ana_s2;
    if (bip_s2) begin
      level = ana_s2 ^ MSB_ONLY;
    end
    trial = sar | (MSB_ONLY >> bit_idx);
  end

  // Free-running trial divider, a stand-in for the internal clock.
  // Its phase is not tied to the start, so a conversion may take up to one
  // extra trial period; checks downstream allow for that spread.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div <= '0;
    end else if (div == 5'(TRIAL_DIV - 1)) begin
      div <= '0;
    end else begin
      div <= div + 5'h01;
    end
  end
  assign trial_en = (div == 5'(TRIAL_DIV - 1));

  // Length of the current high level of blank/convert.
  // It saturates at the restart length so a long standby never wraps.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt <= '0;
    end else if (!bc_s2) begin
      hi_cnt <= '0;
    end else if (hi_cnt != 12'(RESTART_CYC)) begin
      hi_cnt <= hi_cnt + 12'h001;
    end
  end

  // Control sequencer. Outputs change only on done and release.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SBCC_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      sar <= '0;
      result <= '0;
      done_q <= 1'b0;
      data_en <= 1'b0;
    end else begin
      case (state)
        // Standby: only a synchronised falling edge starts a cycle.
        SBCC_IDLE: begin
          if (bc_q && !bc_s2) begin
            state <= SBCC_CONV;
            sar <= '0;
            bit_idx <= '0;
          end
        end
        // One trial per divider pulse; a rising blank stops the trials.
        SBCC_CONV: begin
          if (bc_s2) begin
            state <= SBCC_ABORT;
          end else if (trial_en) begin
            // Keep the bit only while the sum stays at or below input.
            if (trial <= level) begin
              sar <= trial;
            end
            if (bit_idx == 4'(DATA_W - 1)) begin
              state <= SBCC_DONE;
            end else begin
              bit_idx <= bit_idx + 4'h1;
            end
          end
        end
        SBCC_ABORT: begin
          // A long enough high pulse clears and arms a fresh cycle.
          if (hi_cnt == 12'(RESTART_CYC) && !bc_s2) begin
            state <= SBCC_CONV;
            sar <= '0;
            bit_idx <= '0;
          end else if (!bc_s2) begin
            state <= SBCC_CONV;
          end
        end
        // Latch the result and pull done low in the same cycle.
        SBCC_DONE: begin
          result <= sar;
          done_q <= 1'b1;
          cnt <= '0;
          state <= SBCC_HOLD;
        end
        // Hold the result; open the data a fixed time after done falls.
        SBCC_HOLD: begin
          if (!data_en && cnt == 12'(DATA_EN_CYC / 2)) begin
            data_en <= 1'b1;
          end
          if (bc_s2) begin
            cnt <= '0;
            data_en <= 1'b1;
            state <= SBCC_RELEASE;
          end else begin
            cnt <= cnt + 12'h001;
          end
        end
        // Count out the release delay while blank stays high.
        SBCC_RELEASE: begin
          if (!bc_s2) begin
            state <= SBCC_HOLD; // blank too short, data kept
            cnt <= 12'(DATA_EN_CYC);
          end else if (cnt == 12'(RELEASE_CYC - 1)) begin
            done_q <= 1'b0;
            data_en <= 1'b0;
            state <= SBCC_IDLE;
          end else begin
            cnt <= cnt + 12'h001;
          end
        end
        // Unused codes fall back to standby.
        default: begin
          state <= SBCC_IDLE;
        end
      endcase
    end
  end

  // Open-drain done: enable low pulls it low. Idle is open (high).
  // Data always carries the last result; only the enable opens the bus,
  // so a blank never disturbs the stored code.
  assign link.done_n_o = 1'b0;
  assign link.done_n_oe_n = ~done_q;
  assign link.data_o = result;
  assign link.data_oe_n = ~data_en;
  // Busy covers an aborted conversion too, since it may still resume.
  assign o_busy = (state == SBCC_CONV) || (state == SBCC_ABORT);
endmodule

// file: verilog/sbcc_pkg.sv
// Shared constants for the blank/convert control of a 10-bit SAR converter.
// Assumes a single 200 MHz clock on both ends.
package sbcc_pkg;
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned DATA_W = 10;
  // Data-enable delay after done falls; must not exceed 500 ns.
  localparam int unsigned DATA_EN_NS = 500;
  localparam int unsigned DATA_EN_CYC = (DATA_EN_NS * 1000) / CLK_PERIOD_PS;
  // Release of done after blank/convert returns high, about 1.5 us.
  localparam int unsigned RELEASE_NS = 1500;
  localparam int unsigned RELEASE_CYC = (RELEASE_NS * 1000) / CLK_PERIOD_PS;
  // Least blank pulse that restarts a conversion, 2 us, rounded up.
  localparam int unsigned RESTART_NS = 2000;
  localparam int unsigned RESTART_CYC =
    (RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Time allowed to blank the previous converter, 15 us, rounded down.
  localparam int unsigned HANDOFF_NS = 15000;
  localparam int unsigned HANDOFF_CYC = (HANDOFF_NS * 1000) / CLK_PERIOD_PS;
  // Internal bit-trial clock divider, one trial per period.
  localparam int unsigned TRIAL_DIV = 16;
  localparam int unsigned CNT_W = 12;
  localparam logic [DATA_W-1:0] MSB_ONLY = 10'h200;
  // Nominal unipolar step in microvolts and top transition in millivolts.
  localparam int unsigned LSB_UV = 9766;
  localparam int unsigned TOP_MV = 9990;
  typedef enum logic [2:0] {
    SBCC_IDLE, SBCC_CONV, SBCC_ABORT, SBCC_DONE, SBCC_HOLD, SBCC_RELEASE
  } sbcc_state_e;
endpackage

// file: verilog/sbcc_link_if.sv
// Interface joining the converter end and the host end.
// Assumes the testbench resolves the shared data and done wires.
`timescale 1ns/1ps
interface sbcc_link_if;
  logic blank_conv;
  logic done_n_o;
  logic done_n_oe_n;
  logic [9:0] data_o;
  logic data_oe_n;
  logic bipolar_open;
  modport device (
    input blank_conv, input bipolar_open,
    output done_n_o, output done_n_oe_n, output data_o, output data_oe_n
  );
  modport host (
    output blank_conv, output bipolar_open,
    input done_n_o, input done_n_oe_n, input data_o, input data_oe_n
  );
endinterface

// file: verilog/sbcc_host.sv
// Host end: drives blank/convert in pulse or multiplex style and reads data.
// Assumes done and data arrive from another device and are synchronised.
`timescale 1ns/1ps
module sbcc_host (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  sbcc_link_if.host link,
  input wire logic i_start,
  input wire logic i_pulse_mode,
  input wire logic i_bipolar,
  output logic o_valid,
  output logic [sbcc_pkg::DATA_W-1:0] o_data,
  output logic o_busy
);
  import sbcc_pkg::*;

  typedef enum logic [1:0] {
    SBCH_BLANK, SBCH_WAIT, SBCH_READ, SBCH_PULSE
  } sbcc_host_state_e;

  sbcc_host_state_e state;
  logic dn_s1;
  logic dn_s2;
  logic [DATA_W-1:0] d_s1;
  logic [DATA_W-1:0] d_s2;
  logic [CNT_W-1:0] cnt;
  logic bc;
  logic done_low;

  // Resolve the open-drain line locally: low only when pulled.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dn_s1 <= 1'b1;
      dn_s2 <= 1'b1;
      d_s1 <= '0;
      d_s2 <= '0;
    end else begin
      dn_s1 <= link.done_n_oe_n | link.done_n_o;
      dn_s2 <= dn_s1;
      d_s1 <= link.data_o;
      d_s2 <= d_s1;
    end
  end
  assign done_low = ~dn_s2;

  // Blank high hold is always at least 2 us before a new low.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= SBCH_BLANK;
      bc <= 1'b1;
      cnt <= '0;
      o_valid <= 1'b0;
      o_data <= '0;
    end else begin
      o_valid <= 1'b0;
      case (state)
        SBCH_BLANK: begin
          if (cnt != 12'(RESTART_CYC)) begin
            cnt <= cnt + 12'h001;
          end else if (i_start) begin
            bc <= 1'b0;
            cnt <= '0;
            state <= SBCH_WAIT;
          end
        end
        SBCH_WAIT: begin
          if (done_low) begin
            cnt <= '0;
            state <= SBCH_READ;
          end
        end
        SBCH_READ: begin
          // Wait for the data enable window, then sample.
          if (cnt == 12'(DATA_EN_CYC + 4)) begin
            o_data <= d_s2;
            o_valid <= 1'b1;
            cnt <= '0;
            if (i_pulse_mode) begin
              state <= SBCH_PULSE;
            end else begin
              bc <= 1'b1;
              state <= SBCH_BLANK;
            end
          end else begin
            cnt <= cnt + 12'h001;
          end
        end
        SBCH_PULSE: begin
          // Line stays low; a start fires a 2 us positive pulse.
          if (bc) begin
            if (cnt == 12'(RESTART_CYC)) begin
              bc <= 1'b0;
              cnt <= '0;
              state <= SBCH_WAIT;
            end else begin
              cnt <= cnt + 12'h001;
            end
          end else if (i_start) begin
            bc <= 1'b1;
            cnt <= '0;
          end
        end
        default: begin
          state <= SBCH_BLANK;
        end
      endcase
    end
  end

  assign link.blank_conv = bc;
  assign link.bipolar_open = i_bipolar;
  assign o_busy = (state == SBCH_WAIT) || (state == SBCH_READ);
endmodule

// file: testbench/sbcc_props.sv
// Assertions on the link between the converter end and the host end.
// Assumes one clock and instantiation beside the link interface.
`timescale 1ns/1ps
module sbcc_props (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic blank_conv,
  input wire logic done_n_oe_n,
  input wire logic [9:0] data_o,
  input wire logic data_oe_n,
  input wire logic host_blank,
  input wire logic host_done_n_oe_n
);
  logic [9:0] hi_cnt;
  logic [9:0] lo_cnt;
  logic [9:0] host_hi;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  // Run length of blank high; it saturates so long idles never wrap.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hi_cnt <= 10'h000;
    end else if (!blank_conv) begin
      hi_cnt <= 10'h000;
    end else if (hi_cnt != 10'h3FF) begin
      hi_cnt <= hi_cnt + 10'h001;
    end
  end
  // Run length of blank low, saturating likewise.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lo_cnt <= 10'h000;
    end else if (blank_conv) begin
      lo_cnt <= 10'h000;
    end else if (lo_cnt != 10'h3FF) begin
      lo_cnt <= lo_cnt + 10'h001;
    end
  end
  // Run length of the host's own blank high, for its hold duty.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      host_hi <= 10'h000;
    end else if (!host_blank) begin
      host_hi <= 10'h000;
    end else if (host_hi != 10'h3FF) begin
      host_hi <= host_hi + 10'h001;
    end
  end
  // A fresh start follows a blank of at least 2 us.
  sequence s_fresh;
    !blank_conv && hi_cnt >= 10'h190;
  endsequence
  sequence s_open;
    done_n_oe_n && data_oe_n;
  endsequence
  property p_start_quiet;
    $fell(blank_conv) && done_n_oe_n |-> s_open [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet)
    else $error("outputs moved at start");
  property p_abort_quiet;
    $rose(blank_conv) && done_n_oe_n && lo_cnt <= 10'h064 |-> s_open [*8];
  endproperty
  a_abort_quiet: assert property (p_abort_quiet)
    else $error("outputs moved on abort");
  property p_fresh_min;
    s_fresh |-> ##144 done_n_oe_n;
  endproperty
  a_fresh_min: assert property (p_fresh_min)
    else $error("conversion ended too soon");
  property p_conv_done;
    lo_cnt == 10'h0B4 |-> !done_n_oe_n;
  endproperty
  a_conv_done: assert property (p_conv_done)
    else $error("conversion too slow");
  property p_data_window;
    $fell(done_n_oe_n) |-> ##[1:100] !data_oe_n;
  endproperty
  a_data_window: assert property (p_data_window)
    else $error("data late after done");
  property p_data_steady;
    !data_oe_n && !$past(data_oe_n) |-> $stable(data_o);
  endproperty
  a_data_steady: assert property (p_data_steady)
    else $error("data changed while driven");
  property p_release_late;
    $rose(done_n_oe_n) |-> hi_cnt >= 10'h127;
  endproperty
  a_release_late: assert property (p_release_late)
    else $error("done released early");
  property p_standby;
    hi_cnt == 10'h140 |-> s_open;
  endproperty
  a_standby: assert property (p_standby)
    else $error("outputs not open in standby");
  property p_host_hold;
    $fell(host_blank) |-> host_hi >= 10'h190;
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host blank high too short");
  property p_host_read;
    $rose(host_blank) |-> !host_done_n_oe_n;
  endproperty
  a_host_read: assert property (p_host_read)
    else $error("host blanked before done");
endmodule

// file: testbench/sar_adc_blank_convert_control_bench.sv
// Bench joining converter and host, plus a second converter driven here.
// Assumes the package, link interface and both ends are compiled first.
`timescale 1ns/1ps
module sar_adc_blank_convert_control_bench;
  import sbcc_pkg::*;
  logic i_ref_clk;
  logic i_rst_n;
  logic start;
  logic pmode;
  logic bip;
  logic [9:0] code;
  logic valid;
  logic [9:0] rdata;
  logic busy_h;
  logic busy_c;
  logic busy_b;
  int err_count;
  int cmp_count;
  logic [9:0] codes [5] = '{10'h000, 10'h3FF, 10'h200, 10'h155, 10'h2AA};
  sbcc_link_if link();
  sbcc_link_if link2();
  // Done is open drain with a pull-up, so released means high.
  wire done_w = link.done_n_oe_n ? 1'b1 : link.done_n_o;
  sbcc_converter sbcc_converter_inst (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .link(link), .i_analog_code(code), .o_busy(busy_c));
  sbcc_converter sbcc_converter_inst_b (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .link(link2), .i_analog_code(code), .o_busy(busy_b));
  sbcc_host sbcc_host_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .link(link), .i_start(start), .i_pulse_mode(pmode), .i_bipolar(bip),
    .o_valid(valid), .o_data(rdata), .o_busy(busy_h));
  sbcc_props sbcc_props_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .blank_conv(link2.blank_conv), .done_n_oe_n(link2.done_n_oe_n),
    .data_o(link2.data_o), .data_oe_n(link2.data_oe_n),
    .host_blank(link.blank_conv), .host_done_n_oe_n(link.done_n_oe_n));
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One bounded step of any wait; a spent bound ends the run.
  task automatic tick(inout int n);
    @(negedge i_ref_clk);
    n++;
    if (n > 3000) begin
      err_count++;
      summarize();
    end
  endtask
  task automatic t_conv(input logic [9:0] c, input logic b, input logic p);
    int n;
    n = 0;
    while (busy_h !== 1'b0) tick(n);
    code = c;
    bip = b;
    pmode = p;
    start = 1'b1;
    // The request is a level; hold it until the host has taken it.
    while (busy_h !== 1'b1) tick(n);
    start = 1'b0;
    while (valid !== 1'b1) tick(n);
    chk(rdata, c ^ (b ? MSB_ONLY : 10'h000));
    chk(link.data_o, c ^ (b ? MSB_ONLY : 10'h000));
    chk({8'h00, done_w, link.data_oe_n}, 10'h000);
    chk({9'h000, busy_c}, 10'h000);
  endtask
  // Pulse mode keeps blank low, so the result must stay on the bus.
  task automatic t_pulse();
    t_conv(10'h1C7, 1'b0, 1'b1);
    repeat (400) @(negedge i_ref_clk);
    chk(link.data_o, 10'h1C7);
    chk({8'h00, done_w, link.data_oe_n}, 10'h000);
    t_conv(10'h038, 1'b1, 1'b1);
  endtask
  // Second converter: abort then resume, release, then a long restart.
  task automatic t_abort();
    int n;
    link2.blank_conv = 1'b0;
    repeat (80) @(negedge i_ref_clk);
    link2.blank_conv = 1'b1;
    repeat (100) @(negedge i_ref_clk);
    chk({8'h00, link2.done_n_oe_n, link2.data_oe_n}, 10'h003);
    chk({9'h000, busy_b}, 10'h001);
    link2.blank_conv = 1'b0;
    n = 0;
    while (link2.done_n_oe_n !== 1'b0) tick(n);
    // A resumed cycle finishes before even a fresh nine-trial minimum.
    chk({9'h000, n < (DATA_W - 1) * TRIAL_DIV}, 10'h001);
    repeat (60) @(negedge i_ref_clk);
    chk(link2.data_o, code);
    chk({9'h000, link2.data_oe_n}, 10'h000);
    link2.blank_conv = 1'b1;
    repeat (250) @(negedge i_ref_clk);
    chk({9'h000, link2.done_n_oe_n}, 10'h000);
    repeat (80) @(negedge i_ref_clk);
    chk({8'h00, link2.done_n_oe_n, link2.data_oe_n}, 10'h003);
    repeat (100) @(negedge i_ref_clk);
    link2.blank_conv = 1'b0;
    repeat (80) @(negedge i_ref_clk);
    link2.blank_conv = 1'b1;
    // A new input makes a wrongly resumed register show in the result.
    code = ~code;
    repeat (420) @(negedge i_ref_clk);
    link2.blank_conv = 1'b0;
    n = 0;
    while (link2.done_n_oe_n !== 1'b0) tick(n);
    chk({9'h000, n > (DATA_W - 1) * TRIAL_DIV}, 10'h001);
    repeat (60) @(negedge i_ref_clk);
    chk(link2.data_o, code);
  endtask
  // Free-running 200 MHz clock.
  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // Main sequence: reset, multiplexed reads, abort, then pulse mode.
  initial begin
    i_rst_n = 1'b0;
    start = 1'b0;
    pmode = 1'b0;
    bip = 1'b0;
    code = 10'h000;
    link2.blank_conv = 1'b1;
    link2.bipolar_open = 1'b0;
    err_count = 0;
    cmp_count = 0;
    repeat (4) @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      t_conv(codes[i % 5], i >= 5, 1'b0);
    end
    t_abort();
    t_pulse();
    // A 9.990 V input, rounded to the nearest step, is the top code.
    chk(10'((TOP_MV * 1000 + LSB_UV / 2) / LSB_UV), 10'h3FF);
    summarize();
  end
endmodule
